// ---- sps_stepper_phase_sequencer.sv ----
// stepper phase sequencer with an AHB-Lite register slave
`timescale 1ns/100ps
`default_nettype none
module sps_stepper_phase_sequencer #(
	parameter int STEP_CNT_W = 16
) (
	// clock and reset
	input wire logic mclk,
	input wire logic sys_rst,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [sps_pkg::ADDR_W-1:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic [2:0] hsize,
	input wire logic hwrite,
	input wire logic [sps_pkg::DATA_W-1:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [sps_pkg::DATA_W-1:0] hrdata,
	// controller pins
	input wire logic step_clk,
	input wire logic excite_mode,
	input wire logic direction_select,
	input wire logic reset_low_in,
	input wire logic enable,
	// winding drives
	output logic winding_one_fwd,
	output logic winding_one_rev,
	output logic winding_two_fwd,
	output logic winding_two_rev
);
	import sps_pkg::*;

	function automatic logic [3:0] pattern(input logic [POS_W-1:0] p);
		pattern = PHASE_TABLE[{p, 2'b00} +: 4];
	endfunction

	// pin synchroniser and step edge detector
	logic [PIN_N-1:0] pin_meta;
	logic [PIN_N-1:0] pin_sync;
	logic step_prev;
	// phase position, winding pattern and step count
	logic [POS_W-1:0] pos;
	logic [POS_W-1:0] next_pos;
	logic [3:0] wind;
	logic [3:0] next_wind;
	logic [STEP_CNT_W-1:0] steps;
	logic [STEP_CNT_W-1:0] next_steps;
	// bus side state
	logic drive_en;
	logic next_drive_en;
	logic wr_pend;
	logic next_wr_pend;
	logic [REG_SEL_W-1:0] wr_idx;
	logic [REG_SEL_W-1:0] next_wr_idx;
	logic [DATA_W-1:0] next_hrdata;
	// decoded conditions
	logic step_edge;
	logic seq_run;
	logic active;
	logic take;
	logic [REG_SEL_W-1:0] a_idx;
	logic a_hit;

	// pins pass two flip-flops; only the second stage is read by logic
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			pin_meta <= PIN_RST;
			pin_sync <= PIN_RST;
			step_prev <= 1'b0;
		end else begin
			pin_meta <= {enable, reset_low_in, direction_select, excite_mode, step_clk};
			pin_sync <= pin_meta;
			step_prev <= pin_sync[PIN_STEP];
		end
	end

	// rising edge only; falling edges and a steady level leave the position alone
	assign step_edge = pin_sync[PIN_STEP] & ~step_prev;
	assign seq_run = pin_sync[PIN_RSTN];
	assign active = seq_run & pin_sync[PIN_EN] & drive_en;

	// position update: keeps counting while disabled so timing resumes in place
	always_comb begin
		next_pos = pos;
		next_steps = steps;
		if (!seq_run) begin
			next_pos = POS_RST;
			next_steps = '0;
		end else if (step_edge) begin
			next_steps = steps + 1'b1;
			if (pin_sync[PIN_MODE] || pos[0]) begin
				// half-step, or full-step realigning from a half position
				next_pos = pin_sync[PIN_DIR] ? pos - 1'b1 : pos + 1'b1;
			end else begin
				next_pos = pin_sync[PIN_DIR] ? pos - 3'd2 : pos + 3'd2;
			end
		end
	end

	// windings follow the table, forced off by reset or disable
	always_comb begin
		next_wind = active ? pattern(pos) : WIND_OFF;
	end

	// position, step count and winding registers
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			pos <= POS_RST;
			steps <= '0;
			wind <= WIND_OFF;
		end else begin
			pos <= next_pos;
			steps <= next_steps;
			wind <= next_wind;
		end
	end

	// winding pins come straight from the registered pattern
	assign winding_one_fwd = wind[3];
	assign winding_one_rev = wind[2];
	assign winding_two_fwd = wind[1];
	assign winding_two_rev = wind[0];

	// bus address phase decode
	assign take = hsel & htrans[HTRANS_ACT_BIT] & hready;
	assign a_idx = haddr[REG_SEL_LSB +: REG_SEL_W];
	assign a_hit = (haddr[ADDR_W-1:REG_SEL_LSB+REG_SEL_W] == '0);

	// read data is prepared at the address phase; unmapped reads give zero
	always_comb begin
		next_wr_pend = take & hwrite;
		next_wr_idx = take ? a_idx : wr_idx;
		next_hrdata = '0;
		next_drive_en = drive_en;
		// a write lands in its data phase, while hwdata stands
		if (wr_pend && wr_idx == IDX_CTRL) begin
			next_drive_en = hwdata[CTRL_DRIVE_EN_BIT];
		end
		if (take && !hwrite && a_hit) begin
			unique case (a_idx)
				IDX_CTRL: next_hrdata[CTRL_DRIVE_EN_BIT] = drive_en;
				IDX_STATUS: begin
					next_hrdata[ST_POS_LSB +: POS_W] = pos;
					next_hrdata[ST_WIND_LSB +: 4] = wind;
					next_hrdata[ST_ENABLE_BIT] = pin_sync[PIN_EN];
					next_hrdata[ST_RESET_BIT] = pin_sync[PIN_RSTN];
					next_hrdata[ST_MODE_BIT] = pin_sync[PIN_MODE];
					next_hrdata[ST_DIR_BIT] = pin_sync[PIN_DIR];
				end
				IDX_STEPS: next_hrdata[STEP_CNT_W-1:0] = steps;
				default: next_hrdata = '0;
			endcase
		end
		if (!a_hit) begin
			next_wr_pend = 1'b0;
		end
	end

	// bus side registers; the slave never waits and always answers OKAY
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			wr_pend <= 1'b0;
			wr_idx <= IDX_CTRL;
			hrdata <= '0;
			drive_en <= CTRL_DRIVE_EN_RST;
			hreadyout <= 1'b1;
			hresp <= HRESP_OKAY;
		end else begin
			wr_pend <= next_wr_pend;
			wr_idx <= next_wr_idx;
			hrdata <= next_hrdata;
			drive_en <= next_drive_en;
			hreadyout <= 1'b1;
			hresp <= HRESP_OKAY;
		end
	end

	// checker helper: cycles in a row driving with no step edge, saturating at three
	logic [1:0] quiet_cnt;
	logic [1:0] next_quiet_cnt;

	// count quiet cycles, restart on any step edge or cut-off
	always_comb begin
		next_quiet_cnt = 2'h0;
		if (active && !step_edge) begin
			next_quiet_cnt = (quiet_cnt == 2'h3) ? quiet_cnt : quiet_cnt + 2'h1;
		end
	end

	// register the quiet count
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			quiet_cnt <= 2'h0;
		end else begin
			quiet_cnt <= next_quiet_cnt;
		end
	end

	// checks on the sequencer
	default clocking @(posedge mclk); endclocking
	default disable iff (sys_rst);

	a_fwd_full_step: assert property (step_edge && seq_run && !pin_sync[PIN_MODE]
		&& !pin_sync[PIN_DIR] && !pos[0] |=> pos == 3'($past(pos) + 3'd2))
		else $error("full-step forward did not advance by two");
	a_rev_half_step: assert property (step_edge && seq_run && pin_sync[PIN_MODE]
		&& pin_sync[PIN_DIR] |=> pos == 3'($past(pos) - 3'd1))
		else $error("half-step reverse did not retreat by one");
	a_hold_no_edge: assert property (!step_edge && seq_run ##1 seq_run
		|-> $stable(pos))
		else $error("position moved without a rising step edge");
	a_reset_off: assert property (!seq_run |=> pos == POS_RST && wind == WIND_OFF)
		else $error("reset did not clear position and windings");
	a_enable_off: assert property (!pin_sync[PIN_EN] |=> wind == WIND_OFF)
		else $error("windings driven while disabled");
	a_resume_table: assert property (active |=> wind == pattern($past(pos)))
		else $error("windings do not follow the kept position");
	a_init_state: assert property (active && pos == POS_RST |=> wind == WIND_INIT)
		else $error("reset position does not drive one_fwd and two_rev");
	a_mode_keeps: assert property ($changed(pin_sync[PIN_MODE]) && !step_edge && seq_run
		|=> $stable(pos))
		else $error("mode change moved the position");
	a_full_two_on: assert property (active && !pin_sync[PIN_MODE] && !pos[0]
		|=> $countones(wind) == 2 && !(wind[3] && wind[2]) && !(wind[1] && wind[0]))
		else $error("full-step state does not hold two different phases");
	a_half_one_on: assert property (active && pos[0] |=> $countones(wind) == 1)
		else $error("half position does not drive exactly one winding");

	// stepping: rising edges only, by one or two positions, counted even while cut off
	a_fall_ignored: assert property (seq_run && step_prev && !pin_sync[PIN_STEP]
		|=> $stable(pos))
		else $error("falling step edge moved the position");
	a_fwd_half_step: assert property (step_edge && seq_run && pin_sync[PIN_MODE]
		&& !pin_sync[PIN_DIR] |=> pos == 3'($past(pos) + 3'd1))
		else $error("half-step forward did not advance by one");
	a_rev_full_step: assert property (step_edge && seq_run && !pin_sync[PIN_MODE]
		&& pin_sync[PIN_DIR] && !pos[0] |=> pos == 3'($past(pos) - 3'd2))
		else $error("full-step reverse did not retreat by two");
	a_full_realign: assert property (step_edge && seq_run
		&& !pin_sync[PIN_MODE] && pos[0] |=> !pos[0])
		else $error("full-step from a half position did not realign");
	a_steps_count: assert property (step_edge && seq_run
		|=> steps == STEP_CNT_W'($past(steps) + 1'b1))
		else $error("step counter missed a rising edge");
	a_count_disabled: assert property (step_edge && seq_run && !active
		|=> pos != $past(pos))
		else $error("position stopped counting while outputs were cut off");

	// winding patterns: phases never clash, neighbours differ as the mode asks
	a_phase_apart: assert property (!(winding_one_fwd && winding_one_rev)
		&& !(winding_two_fwd && winding_two_rev))
		else $error("both windings of one phase are on");
	a_half_two_on: assert property (active && pin_sync[PIN_MODE] && !pos[0]
		|=> $countones(wind) == 2)
		else $error("whole position in half-step does not drive two windings");
	a_half_adjacent: assert property (step_edge && seq_run && pin_sync[PIN_MODE]
		&& active ##1 active
		|=> $countones(wind ^ $past(wind)) == 1)
		else $error("half-step changed more than one winding");
	a_full_adjacent: assert property (step_edge && seq_run && !pin_sync[PIN_MODE]
		&& !pos[0] && active ##1 active
		|=> $countones(wind ^ $past(wind)) == 2)
		else $error("full-step did not swap exactly one phase");
	a_init_pins: assert property (active && pos == POS_RST
		|=> winding_one_fwd && winding_two_rev && !winding_one_rev && !winding_two_fwd)
		else $error("reset position does not drive the first two phases");

	// cut-off by reset or by the control bit, and hold while the step clock is steady
	a_reset_steps: assert property (!seq_run |=> steps == '0)
		else $error("sequencer reset did not clear the step count");
	a_drive_gate: assert property (!drive_en |=> wind == WIND_OFF)
		else $error("windings driven while the control bit is clear");
	a_hold_steady: assert property (quiet_cnt >= 2'h2 |-> $stable(wind))
		else $error("windings changed with the step clock steady");

	// bus slave: always ready with OKAY, zero read data outside a mapped read
	a_ready_high: assert property (hreadyout)
		else $error("slave inserted a wait state");
	a_resp_okay: assert property (hresp == HRESP_OKAY)
		else $error("slave answered with an error");
	a_read_idle: assert property (!(take && !hwrite) |=> hrdata == '0)
		else $error("read data stands outside a data phase");
	a_unmapped_read: assert property (take && !hwrite && !a_hit |=> hrdata == '0)
		else $error("unmapped read returned data");
	a_status_read: assert property (take && !hwrite && a_hit && a_idx == IDX_STATUS
		|=> hrdata[ST_POS_LSB +: POS_W] == $past(pos)
		&& hrdata[ST_RESET_BIT] == $past(seq_run))
		else $error("status read does not show position and reset level");
	a_steps_read: assert property (take && !hwrite && a_hit && a_idx == IDX_STEPS
		|=> hrdata[STEP_CNT_W-1:0] == $past(steps))
		else $error("step count read does not match the counter");
	a_ctrl_write: assert property (wr_pend && wr_idx == IDX_CTRL
		|=> drive_en == $past(hwdata[CTRL_DRIVE_EN_BIT]))
		else $error("control write did not land in its data phase");
	a_write_ignored: assert property (wr_pend && wr_idx != IDX_CTRL |=> $stable(drive_en))
		else $error("write to a read-only register changed the control bit");
endmodule
`default_nettype wire

// ---- sps_pkg.sv ----
// constants, phase pattern table and register map of the stepper phase sequencer
`default_nettype none
package sps_pkg;
	// system clock
	localparam int CLK_MHZ = 25;
	// least times demanded of the controller, in ns, and their cycle counts
	localparam int RESET_HOLD_NS = 10000;
	localparam int RESET_HOLD_CYC = (RESET_HOLD_NS * CLK_MHZ + 999) / 1000;
	localparam int SETUP_HOLD_NS = 4000;
	localparam int SETUP_HOLD_CYC = (SETUP_HOLD_NS * CLK_MHZ + 999) / 1000;
	// bus layout
	localparam int ADDR_W = 32;
	localparam int DATA_W = 32;
	localparam int REG_SEL_LSB = 2;
	localparam int REG_SEL_W = 4;
	localparam logic [REG_SEL_W-1:0] IDX_CTRL = 4'h0;
	localparam logic [REG_SEL_W-1:0] IDX_STATUS = 4'h1;
	localparam logic [REG_SEL_W-1:0] IDX_STEPS = 4'h2;
	localparam logic [31:0] OFS_CTRL = 32'h0000_0000;
	localparam logic [31:0] OFS_STATUS = 32'h0000_0004;
	localparam logic [31:0] OFS_STEPS = 32'h0000_0008;
	// control register fields
	localparam int CTRL_DRIVE_EN_BIT = 0;
	localparam logic CTRL_DRIVE_EN_RST = 1'b1;
	// status register fields
	localparam int ST_POS_LSB = 0;
	localparam int ST_WIND_LSB = 3;
	localparam int ST_ENABLE_BIT = 7;
	localparam int ST_RESET_BIT = 8;
	localparam int ST_MODE_BIT = 9;
	localparam int ST_DIR_BIT = 10;
	// phase position in half-step units
	localparam int POS_W = 3;
	localparam logic [POS_W-1:0] POS_RST = 3'h0;
	// winding pattern {one_fwd, one_rev, two_fwd, two_rev} per position, position 7 first
	localparam logic [31:0] PHASE_TABLE = 32'h1546_2a89;
	localparam logic [3:0] WIND_OFF = 4'h0;
	localparam logic [3:0] WIND_INIT = 4'h9;
	// synchronised pin vector indices
	localparam int PIN_N = 5;
	localparam int PIN_STEP = 0;
	localparam int PIN_MODE = 1;
	localparam int PIN_DIR = 2;
	localparam int PIN_RSTN = 3;
	localparam int PIN_EN = 4;
	localparam logic [PIN_N-1:0] PIN_RST = 5'h00;
	// bus transfer type bit that marks an active transfer
	localparam int HTRANS_ACT_BIT = 1;
	localparam logic HRESP_OKAY = 1'b0;
endpackage
`default_nettype wire

// ---- sps_ctrl_model.sv ----
// controller model driving the step clock and control levels
`timescale 1ns/100ps
`default_nettype none
module sps_ctrl_model (
	// clock
	input wire logic mclk,
	// control pins
	output logic step_clk,
	output logic excite_mode,
	output logic direction_select,
	output logic reset_low_in,
	output logic enable
);
	// levels at power-up, outputs enabled before stepping
	initial begin
		step_clk = 1'b0;
		excite_mode = 1'b0;
		direction_select = 1'b0;
		reset_low_in = 1'b0;
		enable = 1'b1;
	end
	// hold the sequencer reset low well past 10 us (250 cycles)
	task automatic power_up();
		reset_low_in <= 1'b0;
		repeat (260) @(posedge mclk);
		reset_low_in <= 1'b1;
		repeat (8) @(posedge mclk);
	endtask
	// change levels, then keep a 4 us margin before any step edge
	task automatic set_pins(input logic m, input logic d, input logic e, input logic r);
		excite_mode <= m;
		direction_select <= d;
		enable <= e;
		reset_low_in <= r;
		repeat (110) @(posedge mclk);
	endtask
	// one step pulse, mode and direction held 4 us around the rise
	task automatic pulse();
		step_clk <= 1'b1;
		repeat (110) @(posedge mclk);
		step_clk <= 1'b0;
		repeat (110) @(posedge mclk);
	endtask
endmodule
`default_nettype wire

// ---- sps_stepper_phase_sequencer_tb.sv ----
// testbench of the stepper phase sequencer
`timescale 1ns/100ps
`default_nettype none
module sps_stepper_phase_sequencer_tb;
	import sps_pkg::*;
	// winding pattern per position, position 0 in the low nibble
	localparam logic [31:0] WTAB = 32'h1546_2a89;
	logic mclk, sys_rst, hsel, hwrite;
	logic [1:0] htrans;
	logic [31:0] haddr, hwdata, rd;
	wire logic [31:0] hrdata;
	wire logic hready, hresp;
	wire logic step_clk, excite_mode, direction_select, reset_low_in, enable;
	wire logic w1f, w1r, w2f, w2r;
	wire logic [3:0] wnd;
	logic [2:0] p;
	int n_errors, comparisons;
	assign wnd = {w1f, w1r, w2f, w2r};
	// clock
	initial begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end
	sps_stepper_phase_sequencer i_dut (.mclk(mclk), .sys_rst(sys_rst), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hsize(3'h2), .hwrite(hwrite), .hwdata(hwdata),
		.hready(hready), .hreadyout(hready), .hresp(hresp), .hrdata(hrdata),
		.step_clk(step_clk), .excite_mode(excite_mode), .direction_select(direction_select),
		.reset_low_in(reset_low_in), .enable(enable), .winding_one_fwd(w1f),
		.winding_one_rev(w1r), .winding_two_fwd(w2f), .winding_two_rev(w2r));
	sps_ctrl_model i_ctrl (.mclk(mclk), .step_clk(step_clk), .excite_mode(excite_mode),
		.direction_select(direction_select), .reset_low_in(reset_low_in), .enable(enable));
	// compare and count
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_errors++;
			$display("unexpected %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// one single-word bus transfer, read data left in rd
	task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= w;
		htrans <= 2'h2;
		do @(posedge mclk); while (hready !== 1'b1);
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= d;
		do @(posedge mclk); while (hready !== 1'b1);
		rd = hrdata;
		chk("hresp", {31'h0, hresp}, 32'h0000_0000);
	endtask
	// one step, expected position follows mode and direction
	task automatic step();
		int d;
		d = (excite_mode || p[0]) ? 1 : 2;
		p = direction_select ? p - 3'(d) : p + 3'(d);
		i_ctrl.pulse();
		chk("windings", {28'h0, wnd}, {28'h0, WTAB[p*4 +: 4]});
	endtask
	task automatic test_done();
		$display("comparisons %0d n_errors %0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	// scenarios
	task automatic t_reset();
		chk("windings", {28'h0, wnd}, 32'h0000_0009);
		xfer(1'b0, OFS_CTRL, 32'h0000_0000);
		chk("ctrl", rd, 32'h0000_0001);
		xfer(1'b0, 32'h0000_0040, 32'h0000_0000);
		chk("unmapped", rd, 32'h0000_0000);
		$display("test reset done");
	endtask
	task automatic t_modes();
		i_ctrl.set_pins(1'b0, 1'b0, 1'b1, 1'b1);
		repeat (4) step();
		i_ctrl.set_pins(1'b1, 1'b1, 1'b1, 1'b1);
		repeat (7) step();
		i_ctrl.set_pins(1'b0, 1'b0, 1'b1, 1'b1);
		chk("windings", {28'h0, wnd}, {28'h0, WTAB[p*4 +: 4]});
		repeat (2) step();
		$display("test modes done");
	endtask
	task automatic t_enable();
		i_ctrl.set_pins(1'b0, 1'b0, 1'b0, 1'b1);
		chk("windings", {28'h0, wnd}, 32'h0000_0000);
		p = p + 3'h4;
		repeat (2) i_ctrl.pulse();
		chk("windings", {28'h0, wnd}, 32'h0000_0000);
		i_ctrl.set_pins(1'b0, 1'b0, 1'b1, 1'b1);
		chk("windings", {28'h0, wnd}, {28'h0, WTAB[p*4 +: 4]});
		repeat (50) @(posedge mclk);
		chk("windings", {28'h0, wnd}, {28'h0, WTAB[p*4 +: 4]});
		xfer(1'b1, OFS_CTRL, 32'h0000_0000);
		repeat (4) @(posedge mclk);
		chk("windings", {28'h0, wnd}, 32'h0000_0000);
		xfer(1'b0, OFS_STATUS, 32'h0000_0000);
		chk("status", rd, {21'h0, 4'b0011, 4'h0, p});
		xfer(1'b0, OFS_STEPS, 32'h0000_0000);
		chk("steps", rd, 32'h0000_000f);
		xfer(1'b1, OFS_CTRL, 32'h0000_0001);
		repeat (4) @(posedge mclk);
		chk("windings", {28'h0, wnd}, {28'h0, WTAB[p*4 +: 4]});
		$display("test enable done");
	endtask
	task automatic t_seq_reset();
		i_ctrl.set_pins(1'b0, 1'b0, 1'b1, 1'b0);
		chk("windings", {28'h0, wnd}, 32'h0000_0000);
		i_ctrl.set_pins(1'b0, 1'b0, 1'b1, 1'b1);
		chk("windings", {28'h0, wnd}, 32'h0000_0009);
		xfer(1'b0, OFS_STEPS, 32'h0000_0000);
		chk("steps", rd, 32'h0000_0000);
		$display("test sequencer reset done");
	endtask
	// main sequence
	initial begin
		sys_rst = 1'b1;
		hsel = 1'b0;
		haddr = 32'h0000_0000;
		htrans = 2'h0;
		hwrite = 1'b0;
		hwdata = 32'h0000_0000;
		p = 3'h0;
		repeat (16) @(posedge mclk);
		sys_rst <= 1'b0;
		i_ctrl.power_up();
		t_reset();
		t_modes();
		t_enable();
		t_seq_reset();
		test_done();
	end
	// watchdog
	initial begin
		repeat (20000) @(posedge mclk);
		n_errors++;
		test_done();
	end
endmodule
`default_nettype wire
